// *** logic/adc_seq_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ------------------------------------------------------------
// register word addresses (byte address / 4 on the bus)
// ------------------------------------------------------------
`define REG_MODE0_ADDR 4'h0
`define REG_MODE1_ADDR 4'h1
`define REG_STATUS_ADDR 4'h2
`define REG_TIMING_ADDR 4'h3

// ------------------------------------------------------------
// mode register zero fields
// ------------------------------------------------------------
`define MODE0_ENABLE_BIT 0
`define MODE0_START_BIT 1
`define MODE0_SELECT_BIT 2
`define MODE0_RATE_LSB 3
`define MODE0_RANGE_LSB 6
`define MODE0_RESET 32'h0000_0000

// mode register one fields
`define MODE1_TRIG_LSB 0
`define MODE1_ONESHOT_BIT 2
`define MODE1_MULTI_BIT 3
`define MODE1_RESET 32'h0000_0000

// status register fields
`define STAT_READY_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_DONE_BIT 2
`define STAT_STATE_LSB 4

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_MHZ 100
`define STAB_TIME_NS 1000
`define STAB_CYCLES ((`STAB_TIME_NS * `CLK_MHZ + 999) / 1000)
`define STAB_FAD_CYCLES 2
`define TRIG_DETECT_CYCLES 3
`define CONV_FAD_CYCLES 66

`endif

// *** logic/adc_seq_pkg.sv ***
// types shared by the converter sequencer
package adc_seq_pkg;

  // trigger modes
  typedef enum logic [1:0]
  {
    TRIG_SOFT,
    TRIG_HW_NOWAIT,
    TRIG_HW_WAIT,
    TRIG_ADVANCED
  } trig_mode_t;

  // sequencer states
  typedef enum logic [2:0]
  {
    ST_STOP,
    ST_STAB,
    ST_STANDBY,
    ST_CONV
  } seq_state_t;

endpackage

// *** logic/adc_start_stop_sequencer.sv ***
// start/stop sequencer for the on-chip converter, avalon-mm slave
`timescale 1ns/1ps
`include "adc_seq_regs.svh"

// Summary of operation
// - enable bit zero stops comparator, one enables
// - comparator needs 1 us plus two fad
// - early start waits for stabilization to finish
// - wait mode: hardware sets start on trigger
// - one-shot no-wait/advanced keeps start bit set
// - advanced trigger detected three cycles after source
module adc_start_stop_sequencer
  import adc_seq_pkg::*;
#(
  parameter int STAB_CYCLES = `STAB_CYCLES,
  parameter int CONV_FAD_CYCLES = `CONV_FAD_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic hw_trigger,
  output logic comparator_on,
  output logic conv_active,
  output logic conv_done
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [31:0] mode0_q, mode0_d;
  logic [31:0] mode1_q, mode1_d;
  logic [31:0] readdata_q, readdata_d;
  logic ack_q, ack_d;
  seq_state_t state_q, state_d;
  logic [15:0] stab_cnt_q, stab_cnt_d;
  logic [15:0] conv_cnt_q, conv_cnt_d;
  logic [3:0] div_cnt_q, div_cnt_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic [2:0] trig_pipe_q, trig_pipe_d;
  logic trig_prev_q;

  // fields of the mode registers, plus the tick, trigger and bus access strobes
  logic enable_bit, start_bit;
  logic [2:0] clock_rate_field;
  trig_mode_t trig_mode;
  logic one_shot;
  logic fad_tick, trig_seen, access;

  assign enable_bit = mode0_q[`MODE0_ENABLE_BIT];
  assign start_bit = mode0_q[`MODE0_START_BIT];
  assign clock_rate_field = mode0_q[`MODE0_RATE_LSB +: 3];
  assign trig_mode = trig_mode_t'(mode1_q[`MODE1_TRIG_LSB +: 2]);
  assign one_shot = mode1_q[`MODE1_ONESHOT_BIT];
  assign access = (read | write) & ~ack_q;

  // converter clock divide ratio from the rate field: 2^(4-rate), 1 for rate 4 and up
  function automatic logic [3:0] div_limit(input logic [2:0] rate);
    case (rate)
      3'h0: div_limit = 4'hF;
      3'h1: div_limit = 4'h7;
      3'h2: div_limit = 4'h3;
      3'h3: div_limit = 4'h1;
      default: div_limit = 4'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // converter clock enable divider
  // ------------------------------------------------------------
  always_comb
  begin
    div_cnt_d = div_cnt_q + 4'h1;
    if (div_cnt_q >= div_limit(clock_rate_field))
      div_cnt_d = 4'h0;
  end
  assign fad_tick = (div_cnt_q >= div_limit(clock_rate_field));

  // ------------------------------------------------------------
  // trigger detection: pin pass two flops, advanced adds one
  // ------------------------------------------------------------
  always_comb
  begin
    trig_pipe_d = {trig_pipe_q[1:0], hw_trigger};
  end
  // edge on synchronised level, one stage later in advanced mode
  assign trig_seen = (trig_mode == TRIG_ADVANCED) ?
    (trig_pipe_q[2] & ~trig_prev_q) :
    (trig_pipe_q[1] & ~trig_pipe_q[2]);

  // ------------------------------------------------------------
  // register writes, hardware start and sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    mode0_d = mode0_q;
    mode1_d = mode1_q;
    state_d = state_q;
    stab_cnt_d = stab_cnt_q;
    conv_cnt_d = conv_cnt_q;
    ready_d = ready_q;
    done_d = 1'b0;
    // bus writes land at the edge where waitrequest is seen low,
    // so a master that is still held off never changes a bit;
    // hardware events below still take priority afterwards
    if (write && ack_q)
    begin
      if (address == `REG_MODE0_ADDR)
        mode0_d = {24'h0, writedata[7:0]};
      else if (address == `REG_MODE1_ADDR)
        mode1_d = {28'h0, writedata[3:0]};
    end
    // comparator stops whenever enable reads zero
    if (!mode0_d[`MODE0_ENABLE_BIT])
    begin
      ready_d = 1'b0;
      stab_cnt_d = 16'h0;
    end
    // stabilization counter: 1 us then two converter clocks
    else if (!ready_q)
    begin
      if (stab_cnt_q < STAB_CYCLES[15:0])
        stab_cnt_d = stab_cnt_q + 16'h1;
      else if (fad_tick)
      begin
        stab_cnt_d = stab_cnt_q + 16'h1;
        if (stab_cnt_q >= STAB_CYCLES[15:0] +
            16'(`STAB_FAD_CYCLES) - 16'h1)
          ready_d = 1'b1;
      end
    end
    // wait mode: hardware raises start on trigger
    if (trig_seen && enable_bit && trig_mode == TRIG_HW_WAIT)
      mode0_d[`MODE0_START_BIT] = 1'b1;
    case (state_q)
      ST_STOP:
      begin
        if (mode0_d[`MODE0_ENABLE_BIT])
          state_d = ST_STAB;
      end
      ST_STAB:
      begin
        // start held off until the comparator settles
        if (!mode0_d[`MODE0_ENABLE_BIT])
          state_d = ST_STOP;
        else if (ready_q)
          state_d = ST_STANDBY;
      end
      ST_STANDBY:
      begin
        conv_cnt_d = 16'h0;
        if (!mode0_d[`MODE0_ENABLE_BIT])
          state_d = ST_STOP;
        else if (start_bit && ready_q)
        begin
          if (trig_mode == TRIG_SOFT || trig_mode == TRIG_HW_WAIT)
            state_d = ST_CONV;
          else if (trig_seen)
            state_d = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (!mode0_d[`MODE0_START_BIT] || !mode0_d[`MODE0_ENABLE_BIT])
          state_d = mode0_d[`MODE0_ENABLE_BIT] ? ST_STANDBY : ST_STOP;
        else if (fad_tick)
        begin
          conv_cnt_d = conv_cnt_q + 16'h1;
          if (conv_cnt_q >= CONV_FAD_CYCLES[15:0] - 16'h1)
          begin
            done_d = 1'b1;
            state_d = ST_STANDBY;
            conv_cnt_d = 16'h0;
            // one-shot clears start only in soft and wait modes
            if (one_shot && (trig_mode == TRIG_SOFT ||
                trig_mode == TRIG_HW_WAIT))
              mode0_d[`MODE0_START_BIT] = 1'b0;
          end
        end
      end
      default:
        state_d = ST_STOP;
    endcase
  end

  // ------------------------------------------------------------
  // bus answer: one wait cycle, then ack
  // ------------------------------------------------------------
  always_comb
  begin
    ack_d = access;
    readdata_d = readdata_q;
    if (access && read)
    begin
      case (address)
        `REG_MODE0_ADDR: readdata_d = mode0_q;
        `REG_MODE1_ADDR: readdata_d = mode1_q;
        `REG_STATUS_ADDR:
          readdata_d = {25'h0, 3'(state_q), 1'b0, done_q,
                        (state_q == ST_CONV), ready_q};
        `REG_TIMING_ADDR: readdata_d = 32'(STAB_CYCLES);
        default: readdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      mode0_q <= `MODE0_RESET;
      mode1_q <= `MODE1_RESET;
      state_q <= ST_STOP;
      stab_cnt_q <= 16'h0;
      conv_cnt_q <= 16'h0;
      div_cnt_q <= 4'h0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      trig_pipe_q <= 3'h0;
      trig_prev_q <= 1'b0;
      ack_q <= 1'b0;
      readdata_q <= 32'h0000_0000;
      comparator_on <= 1'b0;
      conv_active <= 1'b0;
      conv_done <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      mode0_q <= mode0_d;
      mode1_q <= mode1_d;
      state_q <= state_d;
      stab_cnt_q <= stab_cnt_d;
      conv_cnt_q <= conv_cnt_d;
      div_cnt_q <= div_cnt_d;
      ready_q <= ready_d;
      done_q <= done_d;
      trig_pipe_q <= trig_pipe_d;
      trig_prev_q <= trig_pipe_q[2];
      ack_q <= ack_d;
      readdata_q <= readdata_d;
      comparator_on <= mode0_d[`MODE0_ENABLE_BIT];
      conv_active <= (state_d == ST_CONV);
      conv_done <= done_d;
      waitrequest <= ~ack_d;
      readdata <= readdata_d;
    end
  end

endmodule

// *** verif/adc_seq_props.sv ***
// port-level checker for the converter start/stop sequencer
`timescale 1ns/1ps
module adc_seq_checker #(
  parameter int STAB_CYCLES = 4
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic hw_trigger,
  input wire logic comparator_on,
  input wire logic conv_active,
  input wire logic conv_done
);
  logic en_q;
  logic en_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------
  // helpers: last enable written, cycles since comparator on
  // ----------------------------------------------------------
  always_comb
  begin
    en_d = en_q;
    if (write && !waitrequest && address == 4'h0)
      en_d = writedata[0];
    cnt_d = comparator_on ? cnt_q + {7'h00, cnt_q != 8'hFF} : 8'h00;
  end
  // saturating count, so a long idle never wraps into a false failure
  always_ff @(posedge clk_sys)
  begin
    en_q <= nrst ? en_d : 1'b0;
    cnt_q <= nrst ? cnt_d : 8'h00;
  end
  a_wait_answer: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("request not answered");
  a_wait_idle: assert property (!read && !write && waitrequest
    |=> waitrequest) else $error("answer without request");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_rdata_hold: assert property ($changed(readdata) |-> $past(read))
    else $error("readdata moved without read");
  a_comp_follow: assert property (en_q == $past(en_q, 2)
    |-> comparator_on == en_q) else $error("comparator off enable");
  a_stab_time: assert property ($rose(conv_active)
    |-> cnt_q >= STAB_CYCLES) else $error("conversion too early");
  a_done_pulse: assert property (conv_done |=> !conv_done)
    else $error("done longer than one cycle");
  a_done_cause: assert property (conv_done |-> $past(conv_active))
    else $error("done without conversion");
  a_conv_len: assert property ($rose(conv_active) |-> conv_active[*6])
    else $error("conversion cut short");
endmodule

bind adc_start_stop_sequencer adc_seq_checker #(
  .STAB_CYCLES(STAB_CYCLES)
) u_chk (.clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .hw_trigger(hw_trigger),
  .comparator_on(comparator_on), .conv_active(conv_active),
  .conv_done(conv_done));

// *** verif/adc_start_stop_sequencer_tb.sv ***
// self-checking bench for the converter start/stop sequencer
`timescale 1ns/1ps
module adc_start_stop_sequencer_tb
  import adc_seq_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic hw_trigger = 1'b0;
  logic comparator_on;
  logic conv_active;
  logic conv_done;
  logic [31:0] rd;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int dly [4];
  trig_mode_t m;

  always #5 clk_sys = ~clk_sys;

  adc_start_stop_sequencer #(.STAB_CYCLES(4), .CONV_FAD_CYCLES(8)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .hw_trigger(hw_trigger),
    .comparator_on(comparator_on), .conv_active(conv_active),
    .conv_done(conv_done));

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one bus access; request held until waitrequest sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clk_sys); while (waitrequest !== 1'b0 && ++n < 100);
    rd = readdata;
    chk("waitrequest", 32'h0, {31'h0, waitrequest});
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // trigger edge, then cycles until the converter runs
  task trig_lat(output int n);
    n = 0;
    @(posedge clk_sys);
    hw_trigger <= 1'b1;
    do @(posedge clk_sys); while (conv_active !== 1'b1 && ++n < 100);
    hw_trigger <= 1'b0;
    chk("conv start", 32'h1, {31'h0, conv_active});
  endtask
  task done_wait();
    int n;
    n = 0;
    do @(posedge clk_sys); while (conv_done !== 1'b1 && ++n < 200);
    chk("done", 32'h1, {31'h0, conv_done});
  endtask
  // clear start first, then enable, then the restart gap of 5 us
  task stop();
    bus(1'b1, 4'h0, 32'h29);
    bus(1'b1, 4'h0, 32'h28);
    repeat (500) @(posedge clk_sys);
  endtask
  task print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard: whole run needs well under 4000 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk("mode0 reset", 32'h0, rd);
    bus(1'b1, 4'h7, 32'hFF);
    bus(1'b0, 4'h7, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    // soft one-shot: start written before settling ends
    bus(1'b1, 4'h1, 32'h4);
    bus(1'b1, 4'h0, 32'h28);
    bus(1'b1, 4'h0, 32'h29);
    bus(1'b1, 4'h0, 32'h2B);
    chk("comp on", 32'h1, {31'h0, comparator_on});
    chk("early hold", 32'h0, {31'h0, conv_active});
    done_wait();
    bus(1'b0, 4'h2, 32'h0);
    chk("ready", 32'h1, rd & 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk("soft clear", 32'h29, rd);
    stop();
    chk("comp off", 32'h0, {31'h0, comparator_on});
    $display("test soft done");
    // no-wait and advanced one-shot keep the start bit
    for (int i = 0; i < 2; i++)
    begin
      m = i ? TRIG_ADVANCED : TRIG_HW_NOWAIT;
      bus(1'b1, 4'h1, {28'h0, 2'h1, m});
      bus(1'b1, 4'h0, 32'h29);
      repeat (20) @(posedge clk_sys);
      bus(1'b1, 4'h0, 32'h2B);
      chk("no trigger", 32'h0, {31'h0, conv_active});
      trig_lat(dly[m]);
      done_wait();
      bus(1'b0, 4'h0, 32'h0);
      chk("start kept", 32'h2B, rd);
      stop();
    end
    chk("adv detect", 32'(dly[1] + 1), 32'(dly[3]));
    $display("test trigger done");
    // wait mode: hardware sets start, one-shot clears it
    bus(1'b1, 4'h1, {28'h0, 2'h1, TRIG_HW_WAIT});
    bus(1'b1, 4'h0, 32'h29);
    repeat (20) @(posedge clk_sys);
    trig_lat(dly[2]);
    done_wait();
    bus(1'b0, 4'h0, 32'h0);
    chk("wait clear", 32'h29, rd);
    stop();
    $display("test wait done");
    print_verdict();
  end
endmodule
